/* File: pkg/psp_pkg.sv */
// Overview of operation
// - The data port acts as a host slave port only while the slave port enable bit (control bit 4) is set.
// - The slave port works only in microcontroller mode, with no external memory bus in use.
// - Enabling the slave port turns three port E pins into the read, write and chip-select inputs, all active low.
// - The three strobe pin direction bits must all be inputs (pattern 111) for the port to work.
// - The host reads and writes the data port latch as one eight-bit latch, asynchronously to the device clock; the code has separate in and out latches.
// - A host write runs from chip-select and write both low until either goes high, and the host holds both low meanwhile.
// - The end of a host write sets the slave port interrupt flag (flag register one bit 7) and input buffer full (control bit 7).
// - A host read starts with chip-select and read both low; the device drives the latch out and sets output buffer full (control bit 6).
// - A firmware write to the latch during a read is driven out at once but does not set output buffer full.
// - When chip-select or read goes high, the device releases the data pins and sets the slave port interrupt flag.
// - Firmware waits for the interrupt flag, then polls input and output buffer full to decide what to do.
package psp_pkg;
  localparam int PSP_DATA_W = 8;
  localparam int PSP_SYNC_STAGES = 2;
  localparam int PSP_CTL_W = 8;
  localparam int PSP_CTL_IBF_BIT = 7;
  localparam int PSP_CTL_OBF_BIT = 6;
  localparam int PSP_CTL_EN_BIT = 4;
  localparam int PSP_FLAG_IRQ_BIT = 7;
  localparam int PSP_DIR_W = 3;
  localparam logic [2:0] PSP_DIR_ALL_IN = 3'h7;
  localparam logic [7:0] PSP_DATA_RST = 8'h00;

  typedef enum logic [1:0] {
    PSP_IDLE,
    PSP_WRITE,
    PSP_READ
  } psp_state_e;
endpackage

/* File: testbench/psp_host.sv */
`timescale 1ns/1ps
module psp_host (
  input wire logic I_MCLK, O_PD_OE_N,
  input wire logic [7:0] O_PD_OUT,
  output logic I_CS_N = 1'b1, I_RD_N = 1'b1, I_WR_N = 1'b1,
  output logic [7:0] I_PD_IN
);
  logic drv = 1'b0;
  logic [7:0] dat = 8'h00;
  // a released bus shows the inverse of the host's last data byte
  assign I_PD_IN = !O_PD_OE_N ? O_PD_OUT : drv ? dat : ~dat;
  task automatic cyc(input logic wr, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge I_MCLK);
    {drv, dat, I_CS_N, I_WR_N, I_RD_N} = {wr, d, 1'b0, !wr, wr};
    repeat (6) @(negedge I_MCLK);
    q = I_PD_IN;
    {I_CS_N, I_WR_N, I_RD_N} = 3'h7;
    repeat (4) @(negedge I_MCLK);
    drv = 1'b0;
    repeat (4) @(negedge I_MCLK);
  endtask
endmodule

/* File: testbench/psp_props.sv */
`timescale 1ns/1ps
module psp_props
  import psp_pkg::*;
(
  input wire logic I_MCLK, I_SYS_RST, I_CS_N, I_RD_N, I_WR_N, I_FW_WR,
  input wire logic I_SLAVE_PORT_ENABLE, I_MCU_MODE, O_PD_OE_N, I_CLK_EN,
  input wire logic O_INPUT_BUFFER_FULL, O_OUTPUT_BUFFER_FULL,
  input wire logic O_SLAVE_PORT_IRQ_FLAG, O_PORT_ACTIVE,
  input wire logic [2:0] I_STROBE_PIN_DIRECTION,
  input wire logic [7:0] I_FW_WDATA, O_PD_OUT, O_SLAVE_PORT_CONTROL
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST || !I_CLK_EN);
  sequence rd_on; !I_CS_N && !I_RD_N && I_WR_N && O_PORT_ACTIVE; endsequence
  sequence wr_on; !I_CS_N && !I_WR_N && O_PORT_ACTIVE; endsequence
  act_decode_a: assert property (O_PORT_ACTIVE ==
    (I_SLAVE_PORT_ENABLE && I_MCU_MODE && I_STROBE_PIN_DIRECTION == 3'h7))
    else $error("bad active");
  ctl_bits_a: assert property (O_SLAVE_PORT_CONTROL[7:5] ==
    {O_INPUT_BUFFER_FULL, O_OUTPUT_BUFFER_FULL, 1'b0}) else $error("bad ctl");
  rd_drive_a: assert property (rd_on[*5] |->
    !O_PD_OE_N && O_OUTPUT_BUFFER_FULL) else $error("no read drive");
  rd_end_a: assert property (!O_PD_OE_N ##1
    (I_CS_N || I_RD_N)[*5] |-> O_PD_OE_N && O_SLAVE_PORT_IRQ_FLAG)
    else $error("no read end");
  wr_end_a: assert property (wr_on[*4] ##1
    (I_CS_N || I_WR_N)[*5] |-> O_INPUT_BUFFER_FULL && O_SLAVE_PORT_IRQ_FLAG)
    else $error("no write end");
  fw_data_a: assert property (I_FW_WR |=>
    O_PD_OUT == $past(I_FW_WDATA)) else $error("latch not loaded");
  obf_keep_a: assert property (O_OUTPUT_BUFFER_FULL |=>
    O_OUTPUT_BUFFER_FULL) else $error("obf dropped");
  off_idle_a: assert property (!O_PORT_ACTIVE[*5] |-> O_PD_OE_N)
    else $error("driving while off");
  freeze_hold_a: assert property (disable iff (I_SYS_RST)
    !I_CLK_EN |=> $stable({O_PD_OE_N, O_INPUT_BUFFER_FULL,
    O_OUTPUT_BUFFER_FULL, O_SLAVE_PORT_IRQ_FLAG, O_PD_OUT}))
    else $error("state moved while frozen");
endmodule
bind psp_slave_port psp_props props_u (.*);

/* File: testbench/psp_slave_port_tb_top.sv */
`timescale 1ns/1ps
module psp_slave_port_tb_top;
  logic I_MCLK = 1'b0, I_SYS_RST = 1'b1, I_CLK_EN = 1'b1, I_FW_WR = 1'b0;
  logic I_FW_RD = 1'b0, I_IBF_CLR = 1'b0, I_IRQ_CLR = 1'b0, I_MCU_MODE = 1'b1;
  logic I_SLAVE_PORT_ENABLE = 1'b1, I_CS_N, I_RD_N, I_WR_N, O_PD_OE_N;
  logic O_INPUT_BUFFER_FULL, O_OUTPUT_BUFFER_FULL, O_SLAVE_PORT_IRQ_FLAG;
  logic O_PORT_ACTIVE;
  logic [2:0] I_STROBE_PIN_DIRECTION = 3'h7;
  logic [4:0] off [3] = '{5'h0f, 5'h17, 5'h1b};
  logic [7:0] I_FW_WDATA = 8'h00, I_PD_IN, O_PD_OUT, O_FW_RDATA, q, fl;
  logic [7:0] O_SLAVE_PORT_CONTROL;
  int fail_count = 0, checks_done = 0;
  assign fl = {O_SLAVE_PORT_CONTROL[7:4], O_PD_OE_N, O_INPUT_BUFFER_FULL,
    O_OUTPUT_BUFFER_FULL, O_SLAVE_PORT_IRQ_FLAG};
  always #2.5 I_MCLK = ~I_MCLK;
  psp_slave_port dut_u (.*);
  psp_host host_u (.*);
  task automatic chk(input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge I_MCLK) s = 1'b0;
    @(negedge I_MCLK);
  endtask
  task automatic end_of_test;
    $display("fails %0d checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_write;
    host_u.cyc(1'b1, 8'ha5, q);
    chk(O_FW_RDATA, 8'ha5);
    chk(fl, 8'h9d);
    pulse(I_FW_RD);
    pulse(I_IRQ_CLR);
    chk(fl, 8'h18);
  endtask
  task automatic t_read;
    fork
      host_u.cyc(1'b0, 8'h00, q);
      begin
        repeat (3) @(negedge I_MCLK);
        I_FW_WDATA = 8'h3c;
        pulse(I_FW_WR);
      end
    join
    chk(q, 8'h3c);
    chk(fl, 8'h5b);
    pulse(I_IRQ_CLR);
  endtask
  task automatic t_off;
    for (int i = 0; i < 3; i++) begin
      {I_SLAVE_PORT_ENABLE, I_MCU_MODE, I_STROBE_PIN_DIRECTION} = off[i];
      host_u.cyc(1'b1, 8'h77, q);
      chk(fl, {3'h2, I_SLAVE_PORT_ENABLE, 4'ha});
      chk(O_FW_RDATA, 8'ha5);
    end
    {I_SLAVE_PORT_ENABLE, I_MCU_MODE, I_STROBE_PIN_DIRECTION} = 5'h1f;
  endtask
  task automatic t_ibf;
    host_u.cyc(1'b1, 8'h5a, q);
    chk(O_FW_RDATA, 8'h5a);
    chk(fl, 8'hdf);
    pulse(I_IBF_CLR);
    pulse(I_IRQ_CLR);
    chk(fl, 8'h5a);
  endtask
  task automatic t_freeze;
    I_CLK_EN = 1'b0;
    host_u.cyc(1'b1, 8'h33, q);
    chk(fl, 8'h5a);
    chk(O_FW_RDATA, 8'h5a);
    I_CLK_EN = 1'b1;
    repeat (4) @(negedge I_MCLK);
    chk(fl, 8'h5a);
  endtask
  initial begin
    repeat (12) @(negedge I_MCLK);
    I_SYS_RST = 1'b0;
    t_write;
    t_read;
    t_off;
    t_ibf;
    t_freeze;
    end_of_test;
  end
  initial begin
    #2000;
    fail_count++;
    end_of_test;
  end
endmodule

/* File: verilog/psp_slave_port.sv */
`timescale 1ns/1ps
module psp_slave_port
  import psp_pkg::*;
#(
  parameter int DATA_W = PSP_DATA_W
) (
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic I_CLK_EN,
  input wire logic I_SLAVE_PORT_ENABLE,
  input wire logic I_MCU_MODE,
  input wire logic [PSP_DIR_W-1:0] I_STROBE_PIN_DIRECTION,
  input wire logic I_FW_WR,
  input wire logic [DATA_W-1:0] I_FW_WDATA,
  input wire logic I_FW_RD,
  input wire logic I_IBF_CLR,
  input wire logic I_IRQ_CLR,
  input wire logic I_CS_N,
  input wire logic I_RD_N,
  input wire logic I_WR_N,
  input wire logic [DATA_W-1:0] I_PD_IN,
  output logic [DATA_W-1:0] O_PD_OUT,
  output logic O_PD_OE_N,
  output logic [DATA_W-1:0] O_FW_RDATA,
  output logic [PSP_CTL_W-1:0] O_SLAVE_PORT_CONTROL,
  output logic O_INPUT_BUFFER_FULL,
  output logic O_OUTPUT_BUFFER_FULL,
  output logic O_SLAVE_PORT_IRQ_FLAG,
  output logic O_PORT_ACTIVE
);
  localparam int STB_CS = 0;
  localparam int STB_RD = 1;
  localparam int STB_WR = 2;
  localparam int STB_N = 3;

  typedef struct packed {
    logic [STB_N-1:0][PSP_SYNC_STAGES-1:0] strobe_sync;
    psp_state_e state;
    logic [DATA_W-1:0] out_latch;
    logic [DATA_W-1:0] in_latch;
    logic input_buffer_full;
    logic output_buffer_full;
    logic irq;
    logic oe_n;
  } psp_s;

  psp_s cur;
  psp_s next_cur;

  logic en_ok;
  logic mode_ok;
  logic dir_ok;
  logic active;
  wire logic [PSP_DIR_W-1:0] dir_in;

  wire logic [STB_N-1:0] strobe_pin_n;
  wire logic [STB_N-1:0] strobe_gated_n;
  wire logic [STB_N-1:0][PSP_SYNC_STAGES-1:0] next_strobe_sync;
  wire logic [STB_N-1:0] strobe_n;
  wire logic [PSP_CTL_W-1:0] ctl_bits;

  logic cs_n;
  logic rd_n;
  logic wr_n;

  logic in_idle;
  logic in_write;
  logic in_read;

  logic wr_start;
  logic rd_start;
  logic wr_end;
  logic rd_end;

  logic ibf_set;
  logic ibf_clear;
  logic irq_set;
  logic irq_clear;
  logic obf_set;
  logic fw_load;

  // enabled, in microcontroller mode, strobe pins all inputs
  assign en_ok = I_SLAVE_PORT_ENABLE;
  assign mode_ok = I_MCU_MODE;

  // every strobe pin must be set as an input
  for (genvar d = 0; d < PSP_DIR_W; d++) begin : gen_dir
    assign dir_in[d] =
      (I_STROBE_PIN_DIRECTION[d] == PSP_DIR_ALL_IN[d]);
  end
  assign dir_ok = &dir_in;
  assign active = en_ok & mode_ok & dir_ok;

  assign strobe_pin_n[STB_CS] = I_CS_N;
  assign strobe_pin_n[STB_RD] = I_RD_N;
  assign strobe_pin_n[STB_WR] = I_WR_N;

  // one synchroniser per strobe pin
  for (genvar g = 0; g < STB_N; g++) begin : gen_sync
    // pins serve as strobes only while active
    assign strobe_gated_n[g] = strobe_pin_n[g] | ~active;
    for (genvar s = 0; s < PSP_SYNC_STAGES; s++) begin : gen_stage
      if (s == 0) begin : gen_first
        assign next_strobe_sync[g][s] = strobe_gated_n[g];
      end else begin : gen_next
        assign next_strobe_sync[g][s] = cur.strobe_sync[g][s-1];
      end
    end
    // only the last stage is read
    assign strobe_n[g] = cur.strobe_sync[g][PSP_SYNC_STAGES-1];
  end

  assign cs_n = strobe_n[STB_CS];
  assign rd_n = strobe_n[STB_RD];
  assign wr_n = strobe_n[STB_WR];

  assign in_idle = (cur.state == PSP_IDLE);
  assign in_write = (cur.state == PSP_WRITE);
  assign in_read = (cur.state == PSP_READ);

  // write wins when both strobes are low
  assign wr_start = active & ~cs_n & ~wr_n;
  assign rd_start = active & ~cs_n & ~rd_n & wr_n;
  assign wr_end = cs_n | wr_n | ~active;
  assign rd_end = cs_n | rd_n | ~active;

  // flag events
  assign ibf_set = in_write & wr_end;
  assign irq_set = (in_write & wr_end) | (in_read & rd_end);
  assign obf_set = (in_idle & rd_start) | (fw_load & ~in_read);
  assign ibf_clear = I_FW_RD | I_IBF_CLR;
  assign irq_clear = I_IRQ_CLR;
  assign fw_load = I_FW_WR;

  always_comb begin
    next_cur = cur;
    next_cur.strobe_sync = next_strobe_sync;
    if (fw_load) begin
      next_cur.out_latch = I_FW_WDATA;
    end
    case (cur.state)
      PSP_IDLE: begin
        if (wr_start) begin
          next_cur.state = PSP_WRITE;
        end else if (rd_start) begin
          next_cur.state = PSP_READ;
          next_cur.oe_n = 1'b0;
        end
      end
      PSP_WRITE: begin
        // the last byte seen before the end is kept
        next_cur.in_latch = I_PD_IN;
        if (wr_end) begin
          next_cur.state = PSP_IDLE;
        end
      end
      PSP_READ: begin
        if (rd_end) begin
          next_cur.state = PSP_IDLE;
          next_cur.oe_n = 1'b1;
        end
      end
      default: begin
        next_cur.state = PSP_IDLE;
        next_cur.oe_n = 1'b1;
      end
    endcase
    // clears come first so a set in the same cycle wins
    if (ibf_clear) begin
      next_cur.input_buffer_full = 1'b0;
    end
    if (ibf_set) begin
      next_cur.input_buffer_full = 1'b1;
    end
    if (irq_clear) begin
      next_cur.irq = 1'b0;
    end
    if (irq_set) begin
      next_cur.irq = 1'b1;
    end
    if (obf_set) begin
      next_cur.output_buffer_full = 1'b1;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      cur.strobe_sync <= '1;
      cur.state <= PSP_IDLE;
      cur.out_latch <= DATA_W'(PSP_DATA_RST);
      cur.in_latch <= DATA_W'(PSP_DATA_RST);
      cur.input_buffer_full <= 1'b0;
      cur.output_buffer_full <= 1'b0;
      cur.irq <= 1'b0;
      cur.oe_n <= 1'b1;
    end else if (I_CLK_EN) begin
      cur <= next_cur;
    end
  end

  // new firmware data goes straight to the pins during a read
  assign O_PD_OUT = cur.out_latch;
  assign O_PD_OE_N = cur.oe_n;
  assign O_FW_RDATA = cur.in_latch;
  assign O_INPUT_BUFFER_FULL = cur.input_buffer_full;
  assign O_OUTPUT_BUFFER_FULL = cur.output_buffer_full;
  assign O_SLAVE_PORT_IRQ_FLAG = cur.irq;
  assign O_PORT_ACTIVE = active;

  // control image: buffer flags, enable, other bits read as zero
  for (genvar b = 0; b < PSP_CTL_W; b++) begin : gen_ctl
    if (b == PSP_CTL_IBF_BIT) begin : gen_ibf
      assign ctl_bits[b] = cur.input_buffer_full;
    end else if (b == PSP_CTL_OBF_BIT) begin : gen_obf
      assign ctl_bits[b] = cur.output_buffer_full;
    end else if (b == PSP_CTL_EN_BIT) begin : gen_en
      assign ctl_bits[b] = I_SLAVE_PORT_ENABLE;
    end else begin : gen_zero
      assign ctl_bits[b] = 1'b0;
    end
  end
  assign O_SLAVE_PORT_CONTROL = ctl_bits;

endmodule
